// ### verilog/uhig_pkg.sv
// register map, field positions and reset values of the irq enable gate
package uhig_pkg;
   localparam logic [11:0] UHIG_OFS_STATUS = 12'h0310;
   localparam logic [11:0] UHIG_OFS_ENABLE = 12'h0314;
   localparam logic [11:0] UHIG_OFS_ISO_OR = 12'h0318;
   localparam logic [11:0] UHIG_OFS_INT_OR = 12'h031C;
   localparam logic [11:0] UHIG_OFS_ATL_OR = 12'h0320;
   localparam logic [11:0] UHIG_OFS_ISO_AND = 12'h0324;
   localparam logic [11:0] UHIG_OFS_INT_AND = 12'h0328;
   localparam logic [11:0] UHIG_OFS_ATL_AND = 12'h032C;
   localparam logic [31:0] UHIG_RST_WORD = 32'h0000_0000;
   // bit positions shared by status and enable
   localparam int UHIG_BIT_ISO = 9;
   localparam int UHIG_BIT_ATL = 8;
   localparam int UHIG_BIT_INT = 7;
   localparam int UHIG_BIT_CLK = 6;
   localparam int UHIG_BIT_SUSP = 5;
   localparam int UHIG_BIT_DMA = 3;
   localparam int UHIG_BIT_SOF = 1;
   localparam int UHIG_NUM_LISTS = 3;
   localparam int UHIG_NUM_DESC = 32;
endpackage : uhig_pkg

// ### verilog/uhig_irq_gate.sv
// interrupt status, per-source enable and descriptor mask logic
//
// Summary of operation
// [R1] bit 9 set lets isochronous descriptor completion raise the request
// [R2] bit 8 set lets async list descriptor completion raise the request
// [R3] bit 7 set lets periodic interrupt descriptor completion raise it
// [R4] bit 6 set lets the clock stable event raise the request
// [R5] bit 5 set lets suspend entry raise the request
// [R6] bit 3 set lets dma completion raise the request
// [R7] bit 1 set lets every frame start raise the request
// [R8] software writes zero into unused enable bits 31..10, 4, 2, 0
// [R9] enable register at 0314h, 32 bits read/write, resets to zero
// [R10] status at 0310h latches events; request needs matching enable bit
// [R11] each of 32 descriptors per list has AND and OR mask bits
// [R12] request is OR of enabled latched events, registered one clock
`timescale 1ns/1ps
`default_nettype none
module uhig_irq_gate
   import uhig_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_cs,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata,
   input wire logic [31:0] i_iso_done_map,
   input wire logic [31:0] i_int_done_map,
   input wire logic [31:0] i_atl_done_map,
   input wire logic i_clock_stable,
   input wire logic i_suspend_entry,
   input wire logic i_dma_done,
   input wire logic i_frame_start,
   output logic o_irq
);

   ////////////////////////////////////////////////////////////////////////
   // completion condition of one list
   function automatic logic list_match(input logic [31:0] done,
                                       input logic [31:0] m_or,
                                       input logic [31:0] m_and);
      logic any_or;
      logic all_and;
      // an all-zero and mask switches the and condition off
      any_or = |(done & m_or);
      all_and = (m_and != UHIG_RST_WORD) && ((done & m_and) == m_and);
      return any_or | all_and;
   endfunction : list_match

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] status;
   logic [31:0] irq_source_enable;
   logic [31:0] mask_or [UHIG_NUM_LISTS];
   logic [31:0] mask_and [UHIG_NUM_LISTS];
   logic [UHIG_NUM_LISTS-1:0] match_q;
   logic [UHIG_NUM_LISTS-1:0] match_now;
   logic [UHIG_NUM_LISTS-1:0] list_event;
   logic [31:0] done_map [UHIG_NUM_LISTS];
   logic [31:0] event_vec;
   logic [31:0] next_status;
   logic [31:0] next_rdata;
   logic wr_en;
   logic rd_en;
   logic sel_status;
   logic sel_enable;
   logic [5:0] sel_mask;
   logic sel_any;
   logic wr_status;
   logic [31:0] clr_mask;
   // gated request of each source
   logic gate_iso;
   logic gate_atl;
   logic gate_int;
   logic gate_clk;
   logic gate_susp;
   logic gate_dma;
   logic gate_sof;

   // list index 0 iso, 1 periodic interrupt, 2 async
   assign done_map[0] = i_iso_done_map;
   assign done_map[1] = i_int_done_map;
   assign done_map[2] = i_atl_done_map;

   assign wr_en = i_cs & i_wr;
   assign rd_en = i_cs & i_rd;
   assign sel_status = (i_addr == UHIG_OFS_STATUS);
   assign sel_enable = (i_addr == UHIG_OFS_ENABLE);
   assign sel_mask[0] = (i_addr == UHIG_OFS_ISO_OR);
   assign sel_mask[1] = (i_addr == UHIG_OFS_INT_OR);
   assign sel_mask[2] = (i_addr == UHIG_OFS_ATL_OR);
   assign sel_mask[3] = (i_addr == UHIG_OFS_ISO_AND);
   assign sel_mask[4] = (i_addr == UHIG_OFS_INT_AND);
   assign sel_mask[5] = (i_addr == UHIG_OFS_ATL_AND);
   // any mapped register; every other address reads zero
   assign sel_any = sel_status | sel_enable | (|sel_mask);

   ////////////////////////////////////////////////////////////////////////
   // descriptor masks and list events
   genvar g;
   generate
      for (g = 0; g < UHIG_NUM_LISTS; g++) begin : g_list
         always_ff @(posedge i_clk_sys) begin
            if (!i_rstn) begin
               mask_or[g] <= UHIG_RST_WORD;
               mask_and[g] <= UHIG_RST_WORD;
            end else if (wr_en) begin
               if (sel_mask[g]) begin
                  mask_or[g] <= i_wdata; // [R11]
               end
               if (sel_mask[g+3]) begin
                  mask_and[g] <= i_wdata; // [R11]
               end
            end
         end
         assign match_now[g] = list_match(done_map[g], mask_or[g],
                                          mask_and[g]); // [R11]
         // edge, so a standing match does not re-set a cleared status bit
         assign list_event[g] = match_now[g] & ~match_q[g];
      end
   endgenerate

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         match_q <= '0;
      end else begin
         match_q <= match_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status: events latch, write one clears, a new event wins the clear
   always_comb begin
      event_vec = UHIG_RST_WORD;
      event_vec[UHIG_BIT_ISO] = list_event[0];
      event_vec[UHIG_BIT_INT] = list_event[1];
      event_vec[UHIG_BIT_ATL] = list_event[2];
      event_vec[UHIG_BIT_CLK] = i_clock_stable;
      event_vec[UHIG_BIT_SUSP] = i_suspend_entry;
      event_vec[UHIG_BIT_DMA] = i_dma_done;
      event_vec[UHIG_BIT_SOF] = i_frame_start;
   end

   assign wr_status = wr_en & sel_status;
   assign clr_mask = wr_status ? i_wdata : UHIG_RST_WORD;
   assign next_status = (status & ~clr_mask) | event_vec; // [R10]

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         status <= UHIG_RST_WORD;
      end else begin
         status <= next_status; // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // enable register; all bits stored, unused ones only gate zero status
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         irq_source_enable <= UHIG_RST_WORD; // [R9]
      end else if (wr_en && sel_enable) begin
         irq_source_enable <= i_wdata; // [R9] [R8]
      end
   end

   // one named gate per source; reserved enable bits only meet status
   // bits that never set, so they cannot raise the request
   assign gate_iso = status[UHIG_BIT_ISO]
                     & irq_source_enable[UHIG_BIT_ISO]; // [R1]
   assign gate_atl = status[UHIG_BIT_ATL]
                     & irq_source_enable[UHIG_BIT_ATL]; // [R2]
   assign gate_int = status[UHIG_BIT_INT]
                     & irq_source_enable[UHIG_BIT_INT]; // [R3]
   assign gate_clk = status[UHIG_BIT_CLK]
                     & irq_source_enable[UHIG_BIT_CLK]; // [R4]
   assign gate_susp = status[UHIG_BIT_SUSP]
                      & irq_source_enable[UHIG_BIT_SUSP]; // [R5]
   assign gate_dma = status[UHIG_BIT_DMA]
                     & irq_source_enable[UHIG_BIT_DMA]; // [R6]
   assign gate_sof = status[UHIG_BIT_SOF]
                     & irq_source_enable[UHIG_BIT_SOF]; // [R7]

   // registered, so the line never glitches during a status write
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= gate_iso | gate_atl | gate_int | gate_clk // [R12]
                  | gate_susp | gate_dma | gate_sof;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data registered; unmapped addresses read zero
   always_comb begin
      next_rdata = UHIG_RST_WORD;
      if (sel_status) begin
         next_rdata = status;
      end else if (sel_enable) begin
         next_rdata = irq_source_enable; // [R9]
      end else if (sel_any) begin
         for (int i = 0; i < UHIG_NUM_LISTS; i++) begin
            if (sel_mask[i]) begin
               next_rdata = mask_or[i];
            end
            if (sel_mask[i+3]) begin
               next_rdata = mask_and[i];
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_rdata <= UHIG_RST_WORD;
      end else if (rd_en) begin
         o_rdata <= next_rdata;
      end
   end

endmodule : uhig_irq_gate
`default_nettype wire

// ### verif/uhig_monitor.sv
// port checker of the irq enable gate
`timescale 1ns/1ps
`default_nettype none
module uhig_monitor
   import uhig_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_cs,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [31:0] o_rdata,
   input wire logic i_clock_stable,
   input wire logic i_suspend_entry,
   input wire logic i_dma_done,
   input wire logic i_frame_start,
   input wire logic o_irq
);
   logic [31:0] en_q;
   wire logic wr_en = i_cs && i_wr && i_addr == UHIG_OFS_ENABLE;
   wire logic rd_cyc = i_cs && i_rd;
   wire logic mapped = i_addr inside {[12'h0310:12'h032F]};
   // shadow of the enable word, so gating can be predicted
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn)
         en_q <= '0;
      else if (wr_en)
         en_q <= i_wdata;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   a_enable_read: assert property (
      rd_cyc && !i_wr && i_addr == UHIG_OFS_ENABLE |=> o_rdata == en_q)
      else $error("enable readback wrong");
   a_unmapped_read: assert property (
      rd_cyc && !mapped |=> o_rdata == '0) else $error("unmapped read");
   a_rdata_hold: assert property (
      !rd_cyc |=> $stable(o_rdata)) else $error("read data moved");
   a_clock_gate: assert property (
      i_clock_stable && en_q[UHIG_BIT_CLK] && !wr_en |-> ##2 o_irq)
      else $error("clock stable irq missing");
   a_susp_gate: assert property (
      i_suspend_entry && en_q[UHIG_BIT_SUSP] && !wr_en |-> ##2 o_irq)
      else $error("suspend irq missing");
   a_dma_gate: assert property (
      i_dma_done && en_q[UHIG_BIT_DMA] && !wr_en |-> ##2 o_irq)
      else $error("dma irq missing");
   a_frame_gate: assert property (
      i_frame_start && en_q[UHIG_BIT_SOF] && !wr_en |-> ##2 o_irq)
      else $error("frame irq missing");
   a_all_masked: assert property (
      $past(en_q) == '0 |-> !o_irq) else $error("irq while disabled");
   c_irq: cover property ($rose(o_irq));
   c_clear: cover property (i_cs && i_wr && i_addr == UHIG_OFS_STATUS);
   c_read: cover property (rd_cyc && i_addr == UHIG_OFS_ENABLE);
endmodule : uhig_monitor
bind uhig_irq_gate uhig_monitor mon_u (.*);
`default_nettype wire

// ### verif/uhig_cpu_model.sv
// processor side register bus model
`timescale 1ns/1ps
`default_nettype none
module uhig_cpu_model
   import uhig_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic [31:0] i_rdata,
   output logic o_cs = 1'b0,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0,
   output logic [11:0] o_addr = '0,
   output logic [31:0] o_wdata = '0
);
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      #1;
      o_cs = 1'b1;
      o_wr = 1'b1;
      o_addr = a;
      // reserved enable bits always go out as zero
      o_wdata = (a == UHIG_OFS_ENABLE) ? d & 32'h0000_03EA : d;
      @(posedge i_clk_sys);
      #1;
      o_cs = 1'b0;
      o_wr = 1'b0;
      o_wdata = ~o_wdata;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge i_clk_sys);
      #1;
      o_cs = 1'b1;
      o_rd = 1'b1;
      o_addr = a;
      @(posedge i_clk_sys);
      #1;
      o_cs = 1'b0;
      o_rd = 1'b0;
      d = i_rdata;
   endtask : rd
endmodule : uhig_cpu_model
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench of the irq enable gate
`timescale 1ns/1ps
`default_nettype none
module testbench import uhig_pkg::*; ;
   logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_cs, i_wr, i_rd, o_irq;
   logic [11:0] i_addr;
   logic [31:0] i_wdata, o_rdata, i_iso_done_map = '0;
   logic [31:0] i_int_done_map = '0, i_atl_done_map = '0;
   logic [3:0] ev = '0;
   wire logic i_clock_stable = ev[0];
   wire logic i_suspend_entry = ev[1];
   wire logic i_dma_done = ev[2];
   wire logic i_frame_start = ev[3];
   int n_mismatch = 0, cmp_count = 0;
   uhig_irq_gate dut_u (.*);
   uhig_cpu_model cpu (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata),
      .o_cs(i_cs), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
      .o_wdata(i_wdata));
   //////////////////////////////////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : step
   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] v);
      cmp_count++;
      if (v !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", s, e, v);
      end
   endtask : chk
   task automatic t_regs;
      logic [31:0] d;
      cpu.rd(UHIG_OFS_ENABLE, d);
      chk("enable reset", UHIG_RST_WORD, d);
      cpu.wr(UHIG_OFS_ENABLE, 32'hFFFF_FFFF);
      cpu.rd(UHIG_OFS_ENABLE, d);
      chk("enable rw", 32'h0000_03EA, d);
      cpu.rd(12'h0300, d);
      chk("unmapped", '0, d);
   endtask : t_regs
   task automatic t_events;
      int pos[4] = '{6, 5, 3, 1};
      for (int k = 0; k < 4; k++) begin
         for (int on = 1; on >= 0; on--) begin
            // off pass enables every other source to catch a wrong bit
            cpu.wr(UHIG_OFS_ENABLE, on ? (32'h1 << pos[k])
               : (32'h0000_03EA ^ (32'h1 << pos[k])));
            ev[k] = 1'b1;
            step(1);
            ev[k] = 1'b0;
            step(1);
            chk("event irq", 32'(on), 32'(o_irq));
            cpu.wr(UHIG_OFS_STATUS, 32'hFFFF_FFFF);
            step(1);
            chk("irq cleared", '0, 32'(o_irq));
         end
      end
   endtask : t_events
   task automatic set_done(input int l, input logic [31:0] v);
      case (l)
         0: i_iso_done_map = v;
         1: i_int_done_map = v;
         default: i_atl_done_map = v;
      endcase
   endtask : set_done
   task automatic t_lists;
      logic [11:0] f_or[3] = '{UHIG_OFS_ISO_OR, UHIG_OFS_INT_OR,
         UHIG_OFS_ATL_OR};
      logic [11:0] f_and[3] = '{UHIG_OFS_ISO_AND, UHIG_OFS_INT_AND,
         UHIG_OFS_ATL_AND};
      int pos[3] = '{UHIG_BIT_ISO, UHIG_BIT_INT, UHIG_BIT_ATL};
      logic [31:0] d;
      for (int l = 0; l < 3; l++) begin
         for (int on = 1; on >= 0; on--) begin
            cpu.wr(UHIG_OFS_ENABLE, on ? (32'h1 << pos[l])
               : (32'h0000_03EA ^ (32'h1 << pos[l])));
            cpu.wr(f_or[l], 32'h0000_0010);
            set_done(l, 32'h0000_0010);
            step(2);
            chk("list or irq", 32'(on), 32'(o_irq));
            cpu.rd(UHIG_OFS_STATUS, d);
            chk("list status", 32'h1 << pos[l], d);
            set_done(l, 32'h0000_0000);
            cpu.wr(f_or[l], 32'h0000_0000);
            cpu.wr(UHIG_OFS_STATUS, 32'hFFFF_FFFF);
            step(1);
            chk("list or cleared", '0, 32'(o_irq));
         end
         cpu.wr(UHIG_OFS_ENABLE, 32'h1 << pos[l]);
         cpu.wr(f_and[l], 32'h0000_0003);
         set_done(l, 32'h0000_0001);
         step(2);
         chk("list and partial", '0, 32'(o_irq));
         set_done(l, 32'h0000_0003);
         step(2);
         chk("list and full", 32'h1, 32'(o_irq));
         set_done(l, 32'h0000_0000);
         cpu.wr(f_and[l], 32'h0000_0000);
         cpu.wr(UHIG_OFS_STATUS, 32'hFFFF_FFFF);
         step(1);
         chk("list and cleared", '0, 32'(o_irq));
      end
   endtask : t_lists
   task automatic results;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
   initial begin
      step(6);
      i_rstn = 1'b1;
      t_regs();
      t_events();
      t_lists();
      results();
   end
endmodule : testbench
`default_nettype wire
